/* rtl/emb_bus.sv */
// external program/data memory bus engine with multiplexed address/data port
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module emb_bus (
  input  wire logic              core_clk_in,          // 20 MHz clock
  input  wire logic              reset_in,             // async reset, high
  input  wire logic              req_valid_in,         // access request
  input  wire emb_pkg::emb_kind_t req_kind_in,         // kind of access
  input  wire logic [15:0]       req_addr_in,          // access address
  input  wire logic [7:0]        req_wdata_in,         // write data
  output logic                   req_ready_out,        // request taken when high
  output logic                   done_out,             // access finished pulse
  output logic                   internal_hit_out,     // move served on chip pulse
  output logic [7:0]             rdata_out,            // byte read
  input  wire logic [3:0]        move_cycles_in,       // move length in mc
  input  wire logic              sram_enable_wr_in,    // load sram enable bit
  input  wire logic              sram_enable_val_in,   // value to load
  output logic                   onchip_sram_enable_out, // current sram enable
  input  wire logic              wait_enable_in,       // stretch feature on
  input  wire logic              stretch_pin_in,       // pin level, low = wait
  input  wire logic              gp_stretch_out_in,    // general port drive value
  input  wire logic              gp_stretch_oe_in,     // general port drive enable
  output logic                   stretch_pin_out,      // pin output value
  output logic                   stretch_pin_oe_out,   // pin output enable
  input  wire logic              external_fetch_select_in, // board strap, held low
  output logic                   ale_out,              // address latch strobe
  output logic                   program_fetch_strobe_n_out, // code read strobe
  output logic                   read_strobe_n_out,    // data read strobe
  output logic                   write_strobe_n_out,   // data write strobe
  input  wire logic [7:0]        low_addr_data_port_in,  // low port input
  output logic [7:0]             low_addr_data_port_out, // low port output
  output logic                   low_addr_data_port_oe_out, // low port enable
  output logic [7:0]             high_addr_port_out    // upper address
);
  import emb_pkg::*;

  typedef enum logic [1:0] {EMB_IDLE, EMB_ADDR, EMB_STROBE} emb_state_t;

  emb_state_t  state, next_state;
  emb_kind_t   kind;
  logic [1:0]  phase;
  logic [3:0]  mc_cnt;
  logic [3:0]  move_len;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        mc_end;
  logic        is_data;
  logic        wait_hold;
  logic        take;
  logic        hit;
  logic        finish;

  function automatic logic [3:0] clamp_len(input logic [3:0] v);
    if (v < MOVE_MC_MIN) begin
      return MOVE_MC_MIN;
    end
    if (v > MOVE_MC_MAX) begin
      return MOVE_MC_MAX;
    end
    return v;
  endfunction

  // ------------------------------------------------------------
  // machine cycle divider
  // ------------------------------------------------------------
  // four clocks each
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      phase <= PHASE_ADDR;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  assign mc_end = (phase == PHASE_LAST);

  // ------------------------------------------------------------
  // sram enable bit
  // ------------------------------------------------------------
  // cleared at reset
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      onchip_sram_enable_out <= SRAM_EN_RESET;
    end else if (sram_enable_wr_in) begin
      onchip_sram_enable_out <= sram_enable_val_in;
    end
  end

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  assign req_ready_out = (state == EMB_IDLE) && mc_end;
  assign take          = req_valid_in && req_ready_out;
  assign is_data       = (kind == EMB_DATA_READ) || (kind == EMB_DATA_WRITE);
  // pin sampled as a synchronous level
  assign wait_hold     = wait_enable_in && !stretch_pin_in;
  // low window served on chip when enabled
  assign hit = ((req_kind_in == EMB_DATA_READ) || (req_kind_in == EMB_DATA_WRITE))
               && onchip_sram_enable_out && (req_addr_in <= SRAM_TOP_ADDR);
  // data moves end after move_len machine cycles, unless held; fetches and code moves after one
  assign finish = mc_end && (((state == EMB_ADDR) && !is_data) ||
                  ((state == EMB_STROBE) && (mc_cnt >= move_len - 4'h1) && !wait_hold));

  always_comb begin
    next_state = state;
    unique case (state)
      EMB_IDLE: begin
        if (take && !hit) begin
          next_state = EMB_ADDR;
        end
      end
      EMB_ADDR: begin
        if (mc_end) begin
          next_state = is_data ? EMB_STROBE : EMB_IDLE;
        end
      end
      EMB_STROBE: begin
        if (finish) begin
          next_state = EMB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= EMB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      kind     <= EMB_FETCH;
      addr     <= 16'h0000;
      wdata    <= 8'h00;
      move_len <= MOVE_MC_MIN;
    end else if (take) begin
      kind     <= req_kind_in;
      addr     <= req_addr_in;
      wdata    <= req_wdata_in;
      move_len <= clamp_len(move_cycles_in);
    end
  end

  // mc_cnt counts machine cycles already spent in this access
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      mc_cnt <= 4'h0;
    end else if (state == EMB_IDLE) begin
      mc_cnt <= 4'h0;
    end else if (mc_end && (mc_cnt != 4'hf)) begin
      mc_cnt <= mc_cnt + 4'h1;
    end
  end

  // on-chip hits answer at once; the sram array itself lives elsewhere
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      done_out         <= 1'b0;
      internal_hit_out <= 1'b0;
      rdata_out        <= 8'h00;
    end else begin
      done_out         <= finish || (take && hit);
      internal_hit_out <= take && hit;
      // byte sampled on the last strobe clock
      if (finish && (kind != EMB_DATA_WRITE)) begin
        rdata_out <= low_addr_data_port_in;
      end
    end
  end

  // ------------------------------------------------------------
  // bus pins, registered from the next state and phase
  // ------------------------------------------------------------
  logic [1:0] next_phase;
  assign next_phase = phase + 2'h1;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ale_out                    <= 1'b0;
      program_fetch_strobe_n_out <= 1'b1;
      read_strobe_n_out          <= 1'b1;
      write_strobe_n_out         <= 1'b1;
      low_addr_data_port_out     <= 8'h00;
      low_addr_data_port_oe_out  <= 1'b0;
      high_addr_port_out         <= 8'h00;
    end else begin
      // one clock at the start of the address cycle
      ale_out <= (next_state == EMB_ADDR) && (next_phase == PHASE_ADDR);
      // code read strobe in second half of the fetch cycle
      program_fetch_strobe_n_out <= !((next_state == EMB_ADDR) && next_phase[1]
                                      && !is_data);
      // read strobe over all strobe cycles
      read_strobe_n_out  <= !((next_state == EMB_STROBE) && (kind == EMB_DATA_READ));
      // write strobe only while data is on the port
      write_strobe_n_out <= !((next_state == EMB_STROBE) && (kind == EMB_DATA_WRITE));
      // address in the first half, then data or released
      // address held through the clock where the latch strobe falls
      if ((next_state == EMB_ADDR) && !next_phase[1]) begin
        low_addr_data_port_out    <= (state == EMB_IDLE) ? req_addr_in[7:0] : addr[7:0];
        low_addr_data_port_oe_out <= 1'b1;
      end else if ((next_state != EMB_IDLE) && (kind == EMB_DATA_WRITE)) begin
        low_addr_data_port_out    <= wdata;
        low_addr_data_port_oe_out <= 1'b1;
      end else begin
        low_addr_data_port_oe_out <= 1'b0;
      end
      // upper address steady until the next access
      if (take && !hit) begin
        high_addr_port_out <= req_addr_in[15:8];
      end
    end
  end

  // ------------------------------------------------------------
  // shared stretch pin
  // ------------------------------------------------------------
  // general drive cut off while stretch is enabled
  assign stretch_pin_oe_out = gp_stretch_oe_in && !wait_enable_in;
  assign stretch_pin_out    = gp_stretch_out_in;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [5:0] strobe_clks;
  logic       waited;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      strobe_clks <= 6'h00;
      waited      <= 1'b0;
    end else if (state == EMB_IDLE) begin
      strobe_clks <= 6'h00;
      waited      <= 1'b0;
    end else if (state == EMB_STROBE) begin
      strobe_clks <= strobe_clks + 6'h01;
      waited      <= waited || (mc_end && wait_hold);
    end
  end

  default clocking emb_cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  a_mc_four_clocks: assert property (
    mc_end |=> !mc_end [*3] ##1 mc_end) else $error("machine cycle not four clocks");
  a_ale_one_clock: assert property (
    $rose(ale_out) |=> !ale_out [*7]) else $error("latch strobe width wrong");
  a_addr_at_fall: assert property (
    $fell(ale_out) |-> low_addr_data_port_oe_out && $stable(low_addr_data_port_out))
    else $error("low address moved at latch strobe fall");
  a_fetch_strobe: assert property (
    !program_fetch_strobe_n_out |-> !low_addr_data_port_oe_out && !is_data
      && ($past(ale_out, 2) || $past(ale_out, 3))) else $error("fetch strobe misplaced");
  a_write_data: assert property (
    !write_strobe_n_out |-> low_addr_data_port_oe_out && (low_addr_data_port_out == wdata))
    else $error("write strobe without data");
  a_read_release: assert property (
    !read_strobe_n_out |-> !low_addr_data_port_oe_out) else $error("port driven during read");
  a_high_steady: assert property (
    (state != EMB_IDLE) && ($past(state) != EMB_IDLE) |-> $stable(high_addr_port_out))
    else $error("upper address changed mid access");
  a_move_length: assert property (
    (state == EMB_STROBE) && (next_state == EMB_IDLE) && !waited && !(mc_end && wait_hold)
      |-> (strobe_clks + 6'h01) == {move_len - 4'h1, 2'b00})
    else $error("move length wrong");
  a_wait_holds: assert property (
    (state == EMB_STROBE) && mc_end && wait_hold |=> state == EMB_STROBE)
    else $error("stretch ignored");
  a_hit_quiet: assert property (
    take && hit |=> (state == EMB_IDLE) && !ale_out [*4]) else $error("internal move on bus");
  a_pin_input: assert property (
    wait_enable_in |-> !stretch_pin_oe_out) else $error("stretch pin driven");

  c_fetch: cover property (take && (req_kind_in == EMB_FETCH) ##[4:8] done_out);
  c_read: cover property ($fell(read_strobe_n_out) ##[4:40] done_out);
  c_write: cover property ($fell(write_strobe_n_out) ##[4:40] done_out);
  c_stretch: cover property ((state == EMB_STROBE) && mc_end && wait_hold);
  c_hit: cover property (internal_hit_out);
endmodule

/* rtl/emb_pkg.sv */
// constants and types shared by the external memory bus interface
package emb_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int          CLK_PERIOD_NS    = 50;
  localparam int          CLOCKS_PER_MC    = 4;
  localparam int          RESET_HOLD_MC    = 2;
  localparam int          RESET_HOLD_CLKS  = RESET_HOLD_MC * CLOCKS_PER_MC;
  localparam logic [1:0]  PHASE_ADDR       = 2'h0;
  localparam logic [1:0]  PHASE_LATCH      = 2'h1;
  localparam logic [1:0]  PHASE_LAST       = 2'h3;
  // ------------------------------------------------------------
  // data-space move length and on-chip sram window
  // ------------------------------------------------------------
  localparam logic [3:0]  MOVE_MC_MIN      = 4'h2;
  localparam logic [3:0]  MOVE_MC_MAX      = 4'h9;
  localparam logic [15:0] SRAM_TOP_ADDR    = 16'h03ff;
  localparam logic        SRAM_EN_RESET    = 1'b0;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    EMB_FETCH,
    EMB_CODE_MOVE,
    EMB_DATA_READ,
    EMB_DATA_WRITE
  } emb_kind_t;
endpackage

/* tb/emb_mem_model.sv */
// external memory with address latch behind the bus engine
`timescale 1ns/1ps
module emb_mem_model (
  input  wire logic        clk_in,       // bus clock
  input  wire logic        ale_in,       // latch strobe
  input  wire logic        fetch_n_in,   // code read strobe
  input  wire logic        rd_n_in,      // data read strobe
  input  wire logic        wr_n_in,      // data write strobe
  input  wire logic [7:0]  drv_in,       // engine low port value
  input  wire logic        drv_oe_in,    // engine low port enable
  input  wire logic [7:0]  high_in,      // upper address
  input  wire logic [4:0]  wait_clks_in, // strobe clocks to wait
  output logic      [7:0]  port_out,     // resolved low port
  output logic             wait_n_out,   // low = wait
  output logic             wr_seen_out,  // write ended pulse
  output logic      [15:0] wr_addr_out,  // last write address
  output logic      [7:0]  wr_data_out   // last write byte
);
  logic [7:0] low_lat;
  logic [7:0] last;
  logic [5:0] cnt;
  logic       wr_prev;
  always_latch begin
    if (ale_in) low_lat <= port_out;
  end
  // answer only under a read strobe
  always_comb begin
    if (drv_oe_in) port_out = drv_in;
    else if (!fetch_n_in || !rd_n_in) port_out = low_lat ^ high_in ^ 8'h5a;
    else port_out = ~last;
  end
  // hold wait for the commanded clocks
  assign wait_n_out = !((!rd_n_in || !wr_n_in) && cnt < 6'(wait_clks_in));
  // byte taken while write strobe low
  always_ff @(posedge clk_in) begin
    last <= port_out;
    wr_prev <= wr_n_in;
    cnt <= (!rd_n_in || !wr_n_in) ? cnt + 6'h1 : 6'h0;
    wr_seen_out <= wr_n_in && !wr_prev;
    if (!wr_n_in) begin
      wr_addr_out <= {high_in, low_lat};
      wr_data_out <= port_out;
    end
  end
endmodule

/* tb/test_emb_bus.sv */
// self-checking bench for the external memory bus engine
`timescale 1ns/1ps
module test_emb_bus;
  import emb_pkg::*;
  typedef struct {
    emb_kind_t  kind;
    logic [7:0] data;
    logic       hit;
    int         lat;
    int         ale0;
    int         take;
  } emb_exp_t;
  logic core_clk_in = 0, reset_in = 1, req_valid_in = 0, sram_enable_wr_in = 0;
  logic sram_enable_val_in = 0, wait_enable_in = 0, gp_stretch_out_in = 0;
  logic gp_stretch_oe_in = 0, external_fetch_select_in = 0, sram_on = 0;
  emb_kind_t req_kind_in = EMB_FETCH;
  logic [15:0] req_addr_in = 0, wr_addr;
  logic [7:0] req_wdata_in = 0, rdata_out, low_addr_data_port_in, low_addr_data_port_out;
  logic [7:0] high_addr_port_out, wr_data;
  logic [3:0] move_cycles_in = 2;
  logic [4:0] wait_clks = 0;
  logic req_ready_out, done_out, internal_hit_out, onchip_sram_enable_out, stretch_pin_out;
  logic stretch_pin_oe_out, ale_out, program_fetch_strobe_n_out, read_strobe_n_out;
  logic write_strobe_n_out, low_addr_data_port_oe_out, wait_n, wr_seen;
  wire stretch_pin_in = stretch_pin_oe_out ? stretch_pin_out : wait_n;
  int errors = 0, checks_done = 0, cyc = 0, ale_cnt = 0;
  integer seed = 32'h5845adc3;
  emb_exp_t q[$], m;
  logic [23:0] wq[$], w;
  always #(CLK_PERIOD_NS / 2) core_clk_in = ~core_clk_in;
  always @(posedge ale_out) ale_cnt++;
  emb_bus u_dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
    .req_kind_in(req_kind_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .req_ready_out(req_ready_out), .done_out(done_out), .internal_hit_out(internal_hit_out),
    .rdata_out(rdata_out), .move_cycles_in(move_cycles_in),
    .sram_enable_wr_in(sram_enable_wr_in), .sram_enable_val_in(sram_enable_val_in),
    .onchip_sram_enable_out(onchip_sram_enable_out), .wait_enable_in(wait_enable_in),
    .stretch_pin_in(stretch_pin_in), .gp_stretch_out_in(gp_stretch_out_in),
    .gp_stretch_oe_in(gp_stretch_oe_in), .stretch_pin_out(stretch_pin_out),
    .stretch_pin_oe_out(stretch_pin_oe_out),
    .external_fetch_select_in(external_fetch_select_in), .ale_out(ale_out),
    .program_fetch_strobe_n_out(program_fetch_strobe_n_out),
    .read_strobe_n_out(read_strobe_n_out), .write_strobe_n_out(write_strobe_n_out),
    .low_addr_data_port_in(low_addr_data_port_in),
    .low_addr_data_port_out(low_addr_data_port_out),
    .low_addr_data_port_oe_out(low_addr_data_port_oe_out),
    .high_addr_port_out(high_addr_port_out));
  emb_mem_model u_mem (.clk_in(core_clk_in), .ale_in(ale_out),
    .fetch_n_in(program_fetch_strobe_n_out), .rd_n_in(read_strobe_n_out),
    .wr_n_in(write_strobe_n_out), .drv_in(low_addr_data_port_out),
    .drv_oe_in(low_addr_data_port_oe_out), .high_in(high_addr_port_out),
    .wait_clks_in(wait_clks), .port_out(low_addr_data_port_in), .wait_n_out(wait_n),
    .wr_seen_out(wr_seen), .wr_addr_out(wr_addr), .wr_data_out(wr_data));
  // ------------------------------------------------------------
  // checks and stimulus
  // ------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_num(input int got, input int exp, input string what);
    checks_done++;
    if (got != exp) begin
      errors++;
      $display("Error at %0t: %s got %0d want %0d", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic access(input emb_kind_t k, input logic [15:0] a, input int mc, input int wt);
    emb_exp_t e;
    int l;
    l = mc < 2 ? 2 : mc > 9 ? 9 : mc;
    e.kind = k;
    e.hit = sram_on && k >= EMB_DATA_READ && a <= SRAM_TOP_ADDR;
    e.lat = e.hit ? 1 : k < EMB_DATA_READ ? 5 : 4 * l + 1 + (wait_enable_in ? 4 * wt : 0);
    e.data = a[7:0] ^ a[15:8] ^ 8'h5a;
    @(negedge core_clk_in);
    req_kind_in = k;
    req_addr_in = a;
    move_cycles_in = 4'(mc);
    req_wdata_in = 8'($random(seed));
    {gp_stretch_out_in, gp_stretch_oe_in} = 2'($random(seed));
    req_valid_in = 1;
    for (int i = 0; i < 60 && req_ready_out !== 1'b1; i++) @(negedge core_clk_in);
    // noted before the take edge: the latch pulse rises on that very edge
    e.take = cyc;
    e.ale0 = ale_cnt;
    @(posedge core_clk_in);
    #1;
    q.push_back(e);
    if (k == EMB_DATA_WRITE && !e.hit) wq.push_back({a, req_wdata_in});
    @(negedge core_clk_in);
    req_valid_in = 0;
    wait_clks = 5'(4 * wt);
  endtask
  task automatic set_sram(input logic v);
    @(negedge core_clk_in);
    sram_enable_wr_in = 1;
    sram_enable_val_in = v;
    sram_on = v;
    @(negedge core_clk_in);
    sram_enable_wr_in = 0;
  endtask
  task automatic drain;
    for (int i = 0; i < 300 && q.size() + wq.size() > 0; i++) @(negedge core_clk_in);
    repeat (8) @(negedge core_clk_in);
  endtask
  always @(negedge core_clk_in) begin
    if (done_out === 1'b1 && q.size() == 0) chk_num(1, 0, "stray done");
    if (done_out === 1'b1 && q.size() > 0) begin
      m = q.pop_front();
      chk_num(cyc - m.take, m.lat, "latency");
      chk8(8'(internal_hit_out), 8'(m.hit), "hit");
      chk_num(ale_cnt - m.ale0, m.hit ? 0 : 1, "latch pulses");
      if (!m.hit && m.kind != EMB_DATA_WRITE) chk8(rdata_out, m.data, "read");
    end
    if (wr_seen === 1'b1 && wq.size() > 0) begin
      w = wq.pop_front();
      chk8(wr_addr[15:8], w[23:16], "write high");
      chk8(wr_addr[7:0], w[15:8], "write low");
      chk8(wr_data, w[7:0], "write data");
    end
  end
  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      $display("Error at %0t: timeout", $time);
      wrap_up;
    end
  end
  initial begin
    repeat (RESET_HOLD_CLKS) @(negedge core_clk_in);
    chk8(8'({ale_out, program_fetch_strobe_n_out, read_strobe_n_out, write_strobe_n_out}),
         8'h7, "reset strobes");
    reset_in = 0;
    chk8(8'(onchip_sram_enable_out), 8'h0, "sram reset");
    for (int i = 0; i < 6; i++) access(emb_kind_t'(i % 2), 16'($random(seed)), 2, 0);
    for (int i = 0; i < 16; i++) access(emb_kind_t'(2 + i % 2), 16'($random(seed)), i, 0);
    access(EMB_DATA_READ, 16'h0000, 2, 0);
    access(EMB_DATA_WRITE, 16'h03ff, 3, 0);
    drain;
    set_sram(1);
    chk8(8'(onchip_sram_enable_out), 8'h1, "sram set");
    for (int i = 0; i < 8; i++) access(emb_kind_t'(i % 4), i[2] ? 16'h0400 : 16'h03ff, 2, 0);
    access(EMB_DATA_READ, 16'h0000, 5, 0);
    drain;
    set_sram(0);
    {gp_stretch_out_in, gp_stretch_oe_in} = 2'h3;
    @(negedge core_clk_in);
    chk8(8'({stretch_pin_oe_out, stretch_pin_out}), 8'h3, "pin general drive");
    wait_enable_in = 1;
    @(negedge core_clk_in);
    chk8(8'(stretch_pin_oe_out), 8'h0, "pin input only");
    for (int i = 0; i < 6; i++) access(emb_kind_t'(2 + i % 2), 16'($random(seed)), 2, i / 2);
    drain;
    wait_enable_in = 0;
    access(EMB_DATA_READ, 16'h8001, 2, 2);
    drain;
    chk_num(q.size() + wq.size(), 0, "left over");
    wrap_up;
  end
endmodule
